// ---- hw/dhs_pkg.sv ----
// Constants, register map and types for the holdover and steering block
package dhs_pkg;
    // Widths
    localparam int NUM_W = 40;
    localparam int FDEV_W = 38;
    localparam int PHASE_W = 45;
    localparam int PIN_SEL_W = 3;
    localparam int GPIO_COUNT = 8;
    localparam int PHASE_SCALE = 2874;

    // Timing of the external step pins, 4 ns clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PIN_MIN_HIGH_NS = 100;
    localparam int PIN_MIN_HIGH_CYC = (PIN_MIN_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PIN_MAX_RATE_KHZ = 5000;
    localparam int PIN_MIN_STEP_CYC = (1000000000 / PIN_MAX_RATE_KHZ) / CLK_PERIOD_PS;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_STEP = 8'h08;
    localparam logic [7:0] OFF_FDEV_LO = 8'h0C;
    localparam logic [7:0] OFF_FDEV_HI = 8'h10;
    localparam logic [7:0] OFF_FBNUM_LO = 8'h14;
    localparam logic [7:0] OFF_FBNUM_HI = 8'h18;
    localparam logic [7:0] OFF_FBEFF_LO = 8'h1C;
    localparam logic [7:0] OFF_FBEFF_HI = 8'h20;
    localparam logic [7:0] OFF_OFS_LO = 8'h24;
    localparam logic [7:0] OFF_OFS_HI = 8'h28;
    localparam logic [7:0] OFF_ANUM_LO = 8'h2C;
    localparam logic [7:0] OFF_ANUM_HI = 8'h30;
    localparam logic [7:0] OFF_AEFF_LO = 8'h34;
    localparam logic [7:0] OFF_AEFF_HI = 8'h38;
    localparam logic [7:0] OFF_FEED_STEP = 8'h3C;
    localparam logic [7:0] OFF_FEED_PERIOD = 8'h40;
    localparam logic [7:0] OFF_PHASE_LO = 8'h44;
    localparam logic [7:0] OFF_PHASE_HI = 8'h48;
    localparam logic [7:0] OFF_HIST_LO = 8'h4C;
    localparam logic [7:0] OFF_HIST_HI = 8'h50;

    // Control register fields
    localparam int CTRL_HIST_EN = 0;
    localparam int CTRL_STEER_EN = 1;
    localparam int CTRL_PIN_MODE = 2;
    localparam int CTRL_LOOP_EN = 3;
    localparam int CTRL_DEN_MODE = 4;
    localparam int CTRL_DL_EN = 5;
    localparam int CTRL_TRIG_SEL = 8;
    localparam int CTRL_DIR_SEL = 12;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [39:0] NUM_RST = 40'h00_0000_0000;
    localparam logic [31:0] FEED_STEP_RST = 32'h0000_0100;
    localparam logic [15:0] FEED_PERIOD_RST = 16'h00FF;
    localparam int HIST_SHIFT = 4;

    typedef enum logic [1:0] {ST_FREE_RUN, ST_ACQUIRE, ST_LOCKED, ST_HOLDOVER} dhs_state_type;
endpackage : dhs_pkg

// ---- hw/dhs_pin_step.sv ----
// Step and direction pin synchroniser with rising-edge step pulse
`timescale 1ns/1ps
module dhs_pin_step #(
    parameter int NPINS = dhs_pkg::GPIO_COUNT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and selection
    input wire logic [NPINS-1:0] gpio_i,
    input wire logic [dhs_pkg::PIN_SEL_W-1:0] trig_sel_i,
    input wire logic [dhs_pkg::PIN_SEL_W-1:0] dir_sel_i,
    // Step request
    output logic step_o,
    output logic down_o
);
    import dhs_pkg::*;

    logic [NPINS-1:0] meta_q;
    logic [NPINS-1:0] sync_q;
    logic trig_prev_q;
    logic trig_now;

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= gpio_i[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    // A 100 ns pulse spans many 4 ns samples, so no edge is missed
    assign trig_now = sync_q[trig_sel_i];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_now;
        end
    end

    // Reselecting the trigger pin may itself look like an edge
    assign step_o = trig_now & ~trig_prev_q;
    assign down_o = sync_q[dir_sel_i];
endmodule : dhs_pin_step

// ---- hw/dhs_top.sv ----
// Holdover control and oscillator steering for one synchronisation domain
// Summary of operation
// - Accumulate tuning history once frequency locked
// - Enter holdover on loss, no qualified input
// - History off: holdover uses offset word
// - History on: offset until valid, then history
// - Set phase unlock flag entering holdover
// - Frequency unlock flag frozen during holdover
// - Qualified input in holdover: reacquire glitch-free
// - History on: loss before valid history enters free-run
// - Step adds or subtracts deviation word
// - Step write 0 steps up, 1 down
// - Pin edge steps, direction pin gives sign
// - Steering off restores programmed feedback numerator
// - Absolute write of feedback numerator accepted
// - Effective analog numerator readable as status
// - Absolute analog: numerator plus offset word
// - Relative analog: offset fed at set rate
// - New offset drops remaining steps, restarts
// - Completion flag once offset fully fed
// - Signed phase offset shifts feedback phase
// - Phase word scales with factor 2874
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
module dhs_top
    import dhs_pkg::*;
#(
    parameter int NPINS = GPIO_COUNT,
    parameter logic [15:0] HIST_MIN_SAMPLES = 16'h0400
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Loop status from the reference monitors and detectors
    input wire logic reference_loss_i,
    input wire logic ref_available_i,
    input wire logic freq_locked_i,
    input wire logic phase_locked_i,
    input wire logic [NUM_W-1:0] tuning_word_i,
    // Step pins
    input wire logic [NPINS-1:0] gpio_i,
    // Loop controls
    output logic [NUM_W-1:0] feedback_numerator_o,
    output logic [NUM_W-1:0] analog_numerator_o,
    output logic [NUM_W-1:0] holdover_word_o,
    output logic [PHASE_W-1:0] phase_offset_word_o,
    output logic holdover_o,
    output logic free_run_o,
    output logic frequency_unlock_flag_o,
    output logic phase_unlock_flag_o
);
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_data;
    logic [7:0] adr;
    logic wr;
    logic [31:0] ctrl_q;
    logic [FDEV_W-1:0] step_deviation_word_q;
    logic [NUM_W-1:0] fb_prog_q;
    logic [NUM_W-1:0] fb_eff_q;
    logic [NUM_W-1:0] offset_q;
    logic [NUM_W-1:0] anum_q;
    logic [NUM_W-1:0] anum_eff_q;
    logic [NUM_W-1:0] fed_q;
    logic [NUM_W-1:0] hist_avg_q;
    logic [NUM_W-1:0] hold_word_q;
    logic [PHASE_W-1:0] phase_q;
    logic [31:0] feed_step_q;
    logic [15:0] feed_period_q;
    logic [15:0] feed_cnt_q;
    logic signed [NUM_W:0] feed_rem_q;
    logic signed [NUM_W:0] feed_delta;
    logic signed [NUM_W:0] feed_lim;
    logic feed_done_q;
    logic [15:0] hist_cnt_q;
    logic hist_valid_q;
    logic signed [NUM_W:0] hist_diff;
    logic signed [NUM_W:0] hist_inc;
    dhs_state_type state_q;
    dhs_state_type state_d;
    logic freq_unlock_q;
    logic phase_unlock_q;
    logic pin_step;
    logic pin_down;
    logic reg_step;
    logic fb_abs_wr;
    logic ofs_commit;
    logic [NUM_W-1:0] ofs_new;
    logic hist_en;
    logic steer_en;
    logic analog_on;

    function automatic logic [31:0] wmerge(input logic [31:0] old_v);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
                r[b*8+:8] = wb_dat_i[b*8+:8];
            end
        end
        return r;
    endfunction : wmerge

    // Bus: one wait state, writes land at the edge that sees ack
    assign adr = {wb_adr_i[7:2], 2'b00};
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    assign hist_en = ctrl_q[CTRL_HIST_EN];
    assign steer_en = ctrl_q[CTRL_STEER_EN];
    // Analog steering only with the 40-bit denominator selected
    assign analog_on = ctrl_q[CTRL_LOOP_EN] & ctrl_q[CTRL_DEN_MODE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i) begin
                rdata_q <= rd_data;
            end
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        case (adr)
            OFF_CTRL: rd_data = ctrl_q;
            OFF_STATUS: rd_data = {24'h00_0000, 2'b00, feed_done_q, hist_valid_q,
                                   free_run_o, holdover_o, phase_unlock_q, freq_unlock_q};
            OFF_FDEV_LO: rd_data = step_deviation_word_q[31:0];
            OFF_FDEV_HI: rd_data = {26'h000_0000, step_deviation_word_q[37:32]};
            OFF_FBNUM_LO: rd_data = fb_prog_q[31:0];
            OFF_FBNUM_HI: rd_data = {24'h00_0000, fb_prog_q[39:32]};
            OFF_FBEFF_LO: rd_data = fb_eff_q[31:0];
            OFF_FBEFF_HI: rd_data = {24'h00_0000, fb_eff_q[39:32]};
            OFF_OFS_LO: rd_data = offset_q[31:0];
            OFF_OFS_HI: rd_data = {24'h00_0000, offset_q[39:32]};
            OFF_ANUM_LO: rd_data = anum_q[31:0];
            OFF_ANUM_HI: rd_data = {24'h00_0000, anum_q[39:32]};
            OFF_AEFF_LO: rd_data = anum_eff_q[31:0];
            OFF_AEFF_HI: rd_data = {24'h00_0000, anum_eff_q[39:32]};
            OFF_FEED_STEP: rd_data = feed_step_q;
            OFF_FEED_PERIOD: rd_data = {16'h0000, feed_period_q};
            OFF_PHASE_LO: rd_data = phase_q[31:0];
            OFF_PHASE_HI: rd_data = {19'h0_0000, phase_q[44:32]};
            OFF_HIST_LO: rd_data = hist_avg_q[31:0];
            OFF_HIST_HI: rd_data = {24'h00_0000, hist_avg_q[39:32]};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            step_deviation_word_q <= {FDEV_W{1'b0}};
            fb_prog_q <= NUM_RST;
            offset_q <= NUM_RST;
            anum_q <= NUM_RST;
            feed_step_q <= FEED_STEP_RST;
            feed_period_q <= FEED_PERIOD_RST;
            phase_q <= {PHASE_W{1'b0}};
        end else if (wr) begin
            case (adr)
                OFF_CTRL: ctrl_q <= wmerge(ctrl_q) & 32'h0000_773F;
                OFF_FDEV_LO: step_deviation_word_q[31:0] <= wmerge(step_deviation_word_q[31:0]);
                OFF_FDEV_HI: step_deviation_word_q[37:32] <=
                    6'(wmerge({26'h000_0000, step_deviation_word_q[37:32]}));
                OFF_FBNUM_LO: fb_prog_q[31:0] <= wmerge(fb_prog_q[31:0]);
                OFF_FBNUM_HI: fb_prog_q[39:32] <= 8'(wmerge({24'h00_0000, fb_prog_q[39:32]}));
                OFF_OFS_LO: offset_q[31:0] <= wmerge(offset_q[31:0]);
                OFF_OFS_HI: offset_q[39:32] <= ofs_new[39:32];
                OFF_ANUM_LO: anum_q[31:0] <= wmerge(anum_q[31:0]);
                OFF_ANUM_HI: anum_q[39:32] <= 8'(wmerge({24'h00_0000, anum_q[39:32]}));
                OFF_FEED_STEP: feed_step_q <= wmerge(feed_step_q);
                OFF_FEED_PERIOD: feed_period_q <= 16'(wmerge({16'h0000, feed_period_q}));
                // Full signed word reaches the phase comparator as written
                OFF_PHASE_LO: phase_q[31:0] <= wmerge(phase_q[31:0]);
                OFF_PHASE_HI: phase_q[44:32] <= 13'(wmerge({19'h0_0000, phase_q[44:32]}));
                default: ;
            endcase
        end
    end

    // Loop operating state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_FREE_RUN: if (ref_available_i & ~reference_loss_i) state_d = ST_ACQUIRE;
            ST_ACQUIRE: begin
                if (reference_loss_i & ~ref_available_i) begin
                    state_d = ST_FREE_RUN;
                end else if (freq_locked_i) begin
                    state_d = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (reference_loss_i & ~ref_available_i) begin
                    // No history yet means no trusted holdover frequency
                    if (hist_en & ~hist_valid_q) begin
                        state_d = ST_FREE_RUN;
                    end else begin
                        state_d = ST_HOLDOVER;
                    end
                end
            end
            // Numerator is handed back to the loop without a jump
            ST_HOLDOVER: if (ref_available_i) state_d = ST_ACQUIRE;
            default: state_d = ST_FREE_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_FREE_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    assign holdover_o = (state_q == ST_HOLDOVER);
    assign free_run_o = (state_q == ST_FREE_RUN);

    // Lock flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_unlock_q <= 1'b1;
            phase_unlock_q <= 1'b1;
        end else if (state_d == ST_HOLDOVER) begin
            phase_unlock_q <= 1'b1;
            freq_unlock_q <= freq_unlock_q;
        end else begin
            freq_unlock_q <= ~freq_locked_i;
            phase_unlock_q <= ~phase_locked_i;
        end
    end

    assign frequency_unlock_flag_o = freq_unlock_q;
    assign phase_unlock_flag_o = phase_unlock_q;

    // Tuning-word history: running average with shift-based weight
    assign hist_diff = $signed({tuning_word_i[NUM_W-1], tuning_word_i})
                     - $signed({hist_avg_q[NUM_W-1], hist_avg_q});
    assign hist_inc = hist_diff >>> HIST_SHIFT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hist_avg_q <= NUM_RST;
            hist_cnt_q <= 16'h0000;
            hist_valid_q <= 1'b0;
        end else if (~hist_en) begin
            hist_cnt_q <= 16'h0000;
            hist_valid_q <= 1'b0;
        end else if (state_q == ST_LOCKED && ~freq_unlock_q) begin
            if (hist_cnt_q == 16'h0000) begin
                hist_avg_q <= tuning_word_i;
            end else begin
                hist_avg_q <= hist_avg_q + hist_inc[NUM_W-1:0];
            end
            if (hist_cnt_q != HIST_MIN_SAMPLES) begin
                hist_cnt_q <= hist_cnt_q + 16'h0001;
            end else begin
                hist_valid_q <= 1'b1;
            end
        end
    end

    // Holdover frequency source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_word_q <= NUM_RST;
        end else if (hist_en & hist_valid_q) begin
            hold_word_q <= hist_avg_q;
        end else begin
            hold_word_q <= fb_prog_q + offset_q;
        end
    end

    assign holdover_word_o = hold_word_q;

    // Digital-loop steering
    dhs_pin_step #(
        .NPINS(NPINS)
    ) u_pin_step (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .gpio_i(gpio_i),
        .trig_sel_i(ctrl_q[CTRL_TRIG_SEL+:PIN_SEL_W]),
        .dir_sel_i(ctrl_q[CTRL_DIR_SEL+:PIN_SEL_W]),
        .step_o(pin_step),
        .down_o(pin_down)
    );

    assign reg_step = wr && adr == OFF_STEP;
    assign fb_abs_wr = wr && adr == OFF_FBNUM_HI;

    // Host enables steering only when locked, so no lock check here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fb_eff_q <= NUM_RST;
        end else if (~steer_en) begin
            fb_eff_q <= fb_prog_q;
        end else if (fb_abs_wr) begin
            fb_eff_q <= {8'(wmerge(32'(fb_prog_q[39:32]))), fb_prog_q[31:0]};
        end else if (reg_step) begin
            if (wb_sel_i[0] & wb_dat_i[0]) begin
                fb_eff_q <= fb_eff_q - {2'b00, step_deviation_word_q};
            end else begin
                fb_eff_q <= fb_eff_q + {2'b00, step_deviation_word_q};
            end
        end else if (ctrl_q[CTRL_PIN_MODE] & pin_step) begin
            if (pin_down) begin
                fb_eff_q <= fb_eff_q - {2'b00, step_deviation_word_q};
            end else begin
                fb_eff_q <= fb_eff_q + {2'b00, step_deviation_word_q};
            end
        end
    end

    assign feedback_numerator_o = fb_eff_q;

    // Analog-loop steering
    assign ofs_new = {8'(wmerge({24'h00_0000, offset_q[39:32]})), offset_q[31:0]};
    assign ofs_commit = wr && adr == OFF_OFS_HI;
    assign feed_lim = $signed({9'h000, feed_step_q});

    always_comb begin
        if (feed_rem_q < 0) begin
            feed_delta = (-feed_rem_q <= feed_lim) ? feed_rem_q : -feed_lim;
        end else begin
            feed_delta = (feed_rem_q <= feed_lim) ? feed_rem_q : feed_lim;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            feed_rem_q <= '0;
            feed_cnt_q <= 16'h0000;
            feed_done_q <= 1'b1;
            fed_q <= NUM_RST;
        end else if (ofs_commit) begin
            // Leftover of an earlier word is abandoned, not finished
            feed_rem_q <= $signed({ofs_new[NUM_W-1], ofs_new});
            feed_cnt_q <= 16'h0000;
            feed_done_q <= 1'b0;
        end else if (hist_en & analog_on & feed_rem_q != 0) begin
            if (feed_cnt_q >= feed_period_q) begin
                feed_cnt_q <= 16'h0000;
                feed_rem_q <= feed_rem_q - feed_delta;
                fed_q <= fed_q + feed_delta[NUM_W-1:0];
                feed_done_q <= (feed_rem_q == feed_delta);
            end else begin
                feed_cnt_q <= feed_cnt_q + 16'h0001;
            end
        end else if (feed_rem_q == 0) begin
            feed_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            anum_eff_q <= NUM_RST;
        end else if (~analog_on) begin
            anum_eff_q <= anum_q;
        end else if (hist_en) begin
            anum_eff_q <= anum_q + fed_q;
        end else begin
            anum_eff_q <= anum_q + offset_q;
        end
    end

    assign analog_numerator_o = anum_eff_q;
    // Host scales the word by VCO rate, 2 and PHASE_SCALE
    assign phase_offset_word_o = phase_q;
endmodule : dhs_top

// ---- tb/dhs_checker.sv ----
// Port assertions for the holdover and steering block
`timescale 1ns/1ps
module dhs_checker
    import dhs_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Loop status and outputs
    input wire logic reference_loss_i,
    input wire logic ref_available_i,
    input wire logic freq_locked_i,
    input wire logic [PHASE_W-1:0] phase_offset_word_o,
    input wire logic holdover_o,
    input wire logic free_run_o,
    input wire logic frequency_unlock_flag_o,
    input wire logic phase_unlock_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence lost_s; $past(reference_loss_i) && !$past(ref_available_i); endsequence
    ack_one_wait_a: assert property (req_s |=> wb_ack_o)
        else $error("ack not one cycle after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    phase_reset_a: assert property (
        disable iff (1'b0) rst_i |=> phase_offset_word_o == '0)
        else $error("phase word not cleared by reset");
    hold_entry_a: assert property ($rose(holdover_o) |-> lost_s)
        else $error("holdover entered without loss");
    free_entry_a: assert property ($rose(free_run_o) |-> lost_s)
        else $error("free-run entered without loss");
    hold_exit_a: assert property (holdover_o && ref_available_i |=> !holdover_o)
        else $error("holdover kept with input available");
    phase_flag_a: assert property (holdover_o |-> phase_unlock_flag_o)
        else $error("phase unlock flag low in holdover");
    freq_freeze_a: assert property (
        holdover_o && $past(holdover_o) |-> $stable(frequency_unlock_flag_o))
        else $error("frequency flag moved in holdover");
    freq_track_a: assert property (!holdover_o && !$past(holdover_o) && !$past(rst_i)
        |-> frequency_unlock_flag_o == !$past(freq_locked_i))
        else $error("frequency flag not following detector");
endmodule : dhs_checker

bind dhs_top dhs_checker dhs_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .reference_loss_i(reference_loss_i),
    .ref_available_i(ref_available_i), .freq_locked_i(freq_locked_i),
    .phase_offset_word_o(phase_offset_word_o), .holdover_o(holdover_o), .free_run_o(free_run_o),
    .frequency_unlock_flag_o(frequency_unlock_flag_o), .phase_unlock_flag_o(phase_unlock_flag_o));

// ---- tb/dhs_pin_driver.sv ----
// Step and direction pin source standing in for the external steering driver
`timescale 1ns/1ps
module dhs_pin_driver (
    // Clock and command
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic down_i,
    // Pins and status
    output logic trig_o,
    output logic dir_o,
    output logic busy_o
);
    logic [5:0] cnt_q = '0;
    initial {trig_o, dir_o} = 2'b00;
    assign busy_o = (cnt_q != 6'h00);
    // High 27 cycles (108 ns), at most one step per 61 cycles, so under 5 MHz
    always @(posedge clk_i) begin
        if (!busy_o && go_i) begin
            cnt_q <= 6'h3C;
            dir_o <= down_i;
        end else if (busy_o) begin
            cnt_q <= cnt_q - 6'h01;
        end
        // Direction settles four cycles before the trigger rises
        trig_o <= (cnt_q > 6'h1E) && (cnt_q < 6'h3A);
    end
endmodule : dhs_pin_driver

// ---- tb/tb_top.sv ----
// Self-checking bench for the holdover and steering block
`timescale 1ns/1ps
module tb_top;
    import dhs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o, rq;
    logic wb_ack_o, trig, dir, busy, go = 1'b0, dn = 1'b0;
    logic [3:0] lp = '0;
    logic [NUM_W-1:0] tune = '0, an_num, hold_word, fb_num;
    logic [PHASE_W-1:0] phase;
    logic [31:0] exp_q[$], msk_q[$];
    int err_count = 0, samples_checked = 0;

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) tune <= 40'({$urandom(), $urandom()});

    dhs_pin_driver dhs_pin_driver_inst (.clk_i(clk_i), .go_i(go), .down_i(dn), .trig_o(trig),
        .dir_o(dir), .busy_o(busy));
    dhs_top #(.HIST_MIN_SAMPLES(16'h0008)) dhs_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .reference_loss_i(lp[3]), .ref_available_i(lp[2]), .freq_locked_i(lp[1]),
        .phase_locked_i(lp[0]), .tuning_word_i(tune), .gpio_i({2'b00, dir, 1'b0, trig, 3'b000}),
        .feedback_numerator_o(fb_num), .analog_numerator_o(an_num), .holdover_word_o(hold_word),
        .phase_offset_word_o(phase), .holdover_o(), .free_run_o(),
        .frequency_unlock_flag_o(), .phase_unlock_flag_o());

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Read results are judged where the acknowledge shows up
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            chk(64'(wb_dat_o & msk_q[0]), 64'(exp_q[0] & msk_q[0]));
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 40) begin
                err_count++;
                tally_and_finish();
            end
        end while (wb_ack_o !== 1'b1);
        rq = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    task automatic wrw(input logic [7:0] a, input logic [63:0] v);
        xfer(1'b1, a, v[31:0]);
        xfer(1'b1, a + 8'h04, v[63:32]);
    endtask : wrw

    task automatic rdw(input logic [7:0] a, input logic [63:0] e, input logic [31:0] m);
        rd(a, e[31:0], '1);
        rd(a + 8'h04, e[63:32], m);
    endtask : rdw

    task automatic loop_in(input logic [3:0] v);
        lp <= v;
        repeat (4) @(posedge clk_i);
    endtask : loop_in

    task automatic pin(input logic down);
        dn <= down;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do @(posedge clk_i); while (busy === 1'b1);
        repeat (5) @(posedge clk_i);
    endtask : pin

    initial begin
        logic [37:0] dev;
        logic [NUM_W-1:0] n0, n1, ofs, an;
        logic [PHASE_W-1:0] ph;
        int k;
        void'($urandom(81101));
        dev = 38'({$urandom(), $urandom()});
        n0 = 40'({$urandom(), $urandom()});
        n1 = 40'({$urandom(), $urandom()});
        ofs = 40'({$urandom(), $urandom()});
        an = 40'({$urandom(), $urandom()});
        ph = 45'(-2 * PHASE_SCALE * int'($urandom_range(1, 99)));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFF_STATUS, 32'h0000_000B, 32'h0000_000F);
        rd(OFF_FEED_STEP, 32'h0000_0100, '1);
        rdw(OFF_PHASE_LO, 64'h0, 32'h0000_1FFF);
        xfer(1'b1, 8'h7C, $urandom());
        rd(8'h7C, 32'h0, '1);
        wrw(OFF_FDEV_LO, 64'(dev));
        wrw(OFF_FBNUM_LO, 64'(n0));
        loop_in(4'b0111);
        rd(OFF_STATUS, 32'h0, 32'h0000_000F);
        xfer(1'b1, OFF_CTRL, 32'h0000_0002);
        xfer(1'b1, OFF_STEP, 32'h0);
        rdw(OFF_FBEFF_LO, n0 + dev, 32'hFF);
        xfer(1'b1, OFF_STEP, 32'h1);
        xfer(1'b1, OFF_STEP, 32'h1);
        rdw(OFF_FBEFF_LO, n0 - dev, 32'hFF);
        wrw(OFF_FBNUM_LO, 64'(n1));
        rdw(OFF_FBEFF_LO, 64'(n1), 32'hFF);
        // Pin steering: trigger pin 3, direction pin 5
        xfer(1'b1, OFF_CTRL, 32'h0000_5306);
        pin(1'b1);
        rdw(OFF_FBEFF_LO, n1 - dev, 32'hFF);
        xfer(1'b1, OFF_CTRL, 32'h0);
        rdw(OFF_FBEFF_LO, 64'(n1), 32'hFF);
        chk(64'(fb_num), 64'(n1));
        wrw(OFF_OFS_LO, 64'(ofs));
        loop_in(4'b1011);
        loop_in(4'b1000);
        rd(OFF_STATUS, 32'h6, 32'hF);
        chk(64'(hold_word), 64'(40'(n1 + ofs)));
        loop_in(4'b0100);
        rd(OFF_STATUS, 32'h0, 32'h4);
        xfer(1'b1, OFF_CTRL, 32'h1);
        loop_in(4'b0111);
        loop_in(4'b1000);
        rd(OFF_STATUS, 32'h8, 32'hC);
        loop_in(4'b0111);
        repeat (40) @(posedge clk_i);
        rd(OFF_STATUS, 32'h10, 32'h10);
        loop_in(4'b1000);
        rd(OFF_STATUS, 32'h14, 32'h1C);
        loop_in(4'b0100);
        xfer(1'b1, OFF_CTRL, 32'h19);
        wrw(OFF_ANUM_LO, 64'(an));
        wrw(OFF_OFS_LO, 64'h12_3456_7800);
        wrw(OFF_OFS_LO, 64'h300);
        rd(OFF_STATUS, 32'h0, 32'h20);
        k = 0;
        do begin
            repeat (50) @(posedge clk_i);
            rd(OFF_STATUS, 32'h13, 32'h1F);
            k++;
        end while (rq[5] !== 1'b1 && k < 40);
        rdw(OFF_AEFF_LO, an + 40'h300, 32'hFF);
        xfer(1'b1, OFF_CTRL, 32'h18);
        wrw(OFF_OFS_LO, 64'(ofs));
        rdw(OFF_AEFF_LO, an + ofs, 32'hFF);
        chk(64'(an_num), 64'(40'(an + ofs)));
        wrw(OFF_PHASE_LO, 64'(ph));
        rdw(OFF_PHASE_LO, 64'(ph), 32'h1FFF);
        chk(64'(phase), 64'(ph));
        tally_and_finish();
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end
endmodule : tb_top
